// >>> ulfb_map.svh
// register offsets, field positions, reset values, filter and map constants and request codes of the feedback framer
`ifndef ULFB_MAP_SVH
`define ULFB_MAP_SVH

`define ULFB_OFF_CTRL      8'h00
`define ULFB_OFF_TBWORDS   8'h04
`define ULFB_OFF_REFDB     8'h08
`define ULFB_OFF_FRAME     8'h0C
`define ULFB_OFF_WIDEBAND  8'h10
`define ULFB_OFF_STATUS    8'h14
`define ULFB_OFF_ACKS      8'h18
`define ULFB_OFF_LUT       8'h40
`define ULFB_LUT_ENTRIES   16

`define ULFB_CTRL_ENABLE   0
`define ULFB_CTRL_DEMODREF 1

`define ULFB_RST_CTRL      2'h1
`define ULFB_RST_TBWORDS   8'h10
`define ULFB_RST_REFDB     8'h00
`define ULFB_MIN_TBWORDS   8'h07

`define ULFB_PAYLOAD_WORDS 6
`define ULFB_PAYLOAD_BITS  192
`define ULFB_PAYLOAD_BYTES 32'h0000_0018
`define ULFB_FRAME_MAX     10'h3FF
`define ULFB_ACK_FIELDS    10
`define ULFB_ACK_NACK      2'h0
`define ULFB_ACK_ACK       2'h1
`define ULFB_ACK_DTX       2'h2
`define ULFB_ACK_UNDEF     2'h3

`define ULFB_PRB_PER_SUB   8
`define ULFB_NUM_SUB       13

// de-noising taps, Q1.15
`define ULFB_TAP_CENTRE    16'sh414C
`define ULFB_TAP_NEAR      16'sh2731
`define ULFB_TAP_OUTER     (-16'sh07D7)

// bias map in quarter dB, slopes scaled by 256
`define ULFB_MAP_KNEE      16'sh0018
`define ULFB_MAP_SLOPE_LO  16'sh01CD
`define ULFB_MAP_OFFS_LO   16'sh0029
`define ULFB_MAP_SLOPE_HI  16'sh011A
`define ULFB_MAP_OFFS_HI   16'sh0018
`define ULFB_DB_PER_LOG2   16'sh00C1

`define ULFB_REQ_UL_SETUP  8'h01
`define ULFB_REQ_DL_SETUP  8'h02
`define ULFB_REQ_DL_BODY   8'h03
`define ULFB_CNF_OK        8'h00
`define ULFB_CNF_UNSUPP    8'h01

`endif

// >>> ulfb_pkg.sv
// types shared by the feedback framer
package ulfb_pkg;
  typedef enum logic [1:0] {ULFB_IDLE, ULFB_SEND} ulfb_state_t;
  typedef logic signed [7:0] ulfb_quality_t;
endpackage

// >>> ulfb_framer.sv
// uplink feedback framer: ack history, frame counter, quality estimates and packet stream
//
// Behaviour
// - payload is six 32-bit words, 192 bits
// - undefined payload bits are zero
// - header, payload, then zero padding to size
// - four-byte header holds carried payload byte count
// - frame counter 0..1023, once per frame
// - counter timed by own receive frame timing
// - ten 2-bit codes: 0 fail, 1 pass, 3 undefined
// - code 2 when control message missing
// - subband quality over eight resource blocks
// - subband 0 is blocks 0..7; wideband over all
// - quality is signed Q6.2, -32 to +31.75
// - demod reference ignores allocation, values undefined
// - nine-tap symmetric raised-cosine de-noising filter
// - noise is mean power of estimate minus filtered
// - gain is mean squared filtered magnitude
// - raw ratio from ref power, gain, noise
// - two-segment linear unbias map, knee 6 dB
// - lookup fine calibration after unbias map
// - quality fields whole bytes; frame counter and ack codes share word one
// - word padding excluded from length field
// - most significant byte and bit first
// - requests, confirmations, indications; control apart
// - every request gets a confirmation
// - uplink setup request is unsupported
`timescale 1ns/1ns
`include "ulfb_map.svh"

module ulfb_framer
  import ulfb_pkg::*;
#(
  parameter int NUM_SUB = `ULFB_NUM_SUB
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               frame_tick,
  input  wire logic               sf_done,
  input  wire logic               sf_crc_ok,
  input  wire logic               sf_ctrl_ok,
  input  wire logic               ce_valid,
  input  wire logic signed [15:0] ce_re,
  input  wire logic signed [15:0] ce_im,
  input  wire logic               ce_sub_end,
  input  wire logic               ce_band_end,
  output logic                    tx_valid,
  output logic      [31:0]        tx_data,
  output logic                    tx_last,
  input  wire logic               tx_ready,
  input  wire logic               req_valid,
  input  wire logic [7:0]         req_type,
  output logic                    cnf_valid,
  output logic      [7:0]         cnf_status
);

  // ---------------- arithmetic helpers ----------------
  function automatic logic [9:0] log2_q4(input logic [47:0] v);
    logic [5:0]  msb;
    logic [47:0] sh;
    msb = 6'h00;
    for (int i = 0; i < 48; i++) begin
      if (v[i]) begin
        msb = 6'(i);
      end
    end
    sh = v << (6'd47 - msb);
    return {msb, sh[46:43]};
  endfunction

  function automatic logic signed [7:0] sat8(input logic signed [15:0] v);
    if (v > 16'sd127) begin
      return 8'sh7F;
    end else if (v < -16'sd128) begin
      return 8'sh80;
    end
    return v[7:0];
  endfunction

  // quarter-dB estimate, unbiased
  function automatic logic signed [7:0] unbiased(input logic [47:0] g,
                                                 input logic [47:0] n,
                                                 input logic signed [7:0] ref_db);
    logic signed [15:0] dl;
    logic signed [31:0] raw;
    logic signed [31:0] m;
    dl = 16'(signed'({6'h00, log2_q4(g)}) - signed'({6'h00, log2_q4(n | 48'h1)}));
    // log2 q4 to dB q2: 10*log10(2)*4/16 scaled by 256
    raw = ((32'(dl) * 32'(`ULFB_DB_PER_LOG2)) >>> 8) + 32'(ref_db);
    if (raw < 32'(`ULFB_MAP_KNEE)) begin
      m = ((raw * 32'(`ULFB_MAP_SLOPE_LO)) >>> 8) - 32'(`ULFB_MAP_OFFS_LO);
    end else begin
      m = ((raw * 32'(`ULFB_MAP_SLOPE_HI)) >>> 8) - 32'(`ULFB_MAP_OFFS_HI);
    end
    if (m > 32'sd127) begin
      m = 32'sd127;
    end else if (m < -32'sd128) begin
      m = -32'sd128;
    end
    return m[7:0];
  endfunction

  // ---------------- registers ----------------
  logic [1:0]          ctrl_r;
  logic [7:0]          tbwords_r;
  logic signed [7:0]   refdb_r;
  logic signed [7:0]   lut_r [`ULFB_LUT_ENTRIES];
  logic [9:0]          frame_r;
  logic [19:0]         acks_r;
  ulfb_quality_t       subq_r [NUM_SUB];
  ulfb_quality_t       wbq_r;
  logic [3:0]          sub_idx_r;
  logic [47:0]         sg_r, sn_r, wg_r, wn_r;
  logic signed [15:0]  tre_r [9];
  logic signed [15:0]  tim_r [9];
  logic [`ULFB_PAYLOAD_BITS-1:0] snap_r;
  logic [15:0]         sent_r;
  logic [15:0]         drop_r;
  ulfb_state_t         state_r;
  logic [7:0]          widx_r;
  logic [31:0]         prdata_r;
  logic                pready_r, pslverr_r, tx_valid_r, tx_last_r, cnf_valid_r;
  logic [31:0]         tx_data_r;
  logic [7:0]          cnf_status_r;

  // ---------------- APB decode ----------------
  wire       apb_setup  = psel & ~penable;
  wire       apb_wr     = psel & penable & pready_r & pwrite;
  wire       hit_lut    = (paddr >= `ULFB_OFF_LUT) &&
                          (paddr < 8'(`ULFB_OFF_LUT + 4 * `ULFB_LUT_ENTRIES));
  wire [3:0] lut_sel    = paddr[5:2];
  wire       hit_ctrl   = (paddr == `ULFB_OFF_CTRL);
  wire       hit_tbw    = (paddr == `ULFB_OFF_TBWORDS);
  wire       hit_ref    = (paddr == `ULFB_OFF_REFDB);
  wire       hit_ro     = (paddr == `ULFB_OFF_FRAME) || (paddr == `ULFB_OFF_WIDEBAND) ||
                          (paddr == `ULFB_OFF_STATUS) || (paddr == `ULFB_OFF_ACKS);
  wire       aligned    = (paddr[1:0] == 2'h0);
  wire       mapped     = aligned & (hit_lut | hit_ctrl | hit_tbw | hit_ref | hit_ro);
  // read-only words refuse writes
  wire       bad        = ~mapped | (pwrite & hit_ro);
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_lut) begin
      rd_word = {24'h00_0000, lut_r[lut_sel]};
    end else begin
      unique case (paddr)
        `ULFB_OFF_CTRL:     rd_word = {30'h0, ctrl_r};
        `ULFB_OFF_TBWORDS:  rd_word = {24'h0, tbwords_r};
        `ULFB_OFF_REFDB:    rd_word = {24'h0, refdb_r};
        `ULFB_OFF_FRAME:    rd_word = {22'h0, frame_r};
        `ULFB_OFF_WIDEBAND: rd_word = {24'h0, wbq_r};
        `ULFB_OFF_STATUS:   rd_word = {drop_r, sent_r};
        `ULFB_OFF_ACKS:     rd_word = {12'h0, acks_r};
        default:            rd_word = 32'h0000_0000;
      endcase
    end
  end

  // zero wait states: ready rises in the access phase right after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & bad;
      prdata_r  <= (apb_setup & ~pwrite & ~bad) ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `ULFB_RST_CTRL;
      tbwords_r <= `ULFB_RST_TBWORDS;
      refdb_r   <= `ULFB_RST_REFDB;
      for (int i = 0; i < `ULFB_LUT_ENTRIES; i++) begin
        lut_r[i] <= 8'sh00;
      end
    end else if (apb_wr & ~bad) begin
      if (hit_ctrl) begin
        ctrl_r <= pwdata[1:0];
      end
      // pad target never below header plus payload
      if (hit_tbw) begin
        tbwords_r <= (pwdata[7:0] < `ULFB_MIN_TBWORDS) ? `ULFB_MIN_TBWORDS : pwdata[7:0];
      end
      if (hit_ref) begin
        refdb_r <= pwdata[7:0];
      end
      if (hit_lut) begin
        lut_r[lut_sel] <= pwdata[7:0];
      end
    end
  end

  // ---------------- frame counter and ack history ----------------
  // missing control wins over crc result
  wire [1:0] ack_code = ~sf_ctrl_ok ? `ULFB_ACK_DTX :
                        (sf_crc_ok ? `ULFB_ACK_ACK : `ULFB_ACK_NACK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= 10'h000;
      acks_r  <= {`ULFB_ACK_FIELDS{`ULFB_ACK_UNDEF}};
    end else begin
      if (frame_tick) begin
        frame_r <= (frame_r == `ULFB_FRAME_MAX) ? 10'h000 : frame_r + 10'h001;
      end
      // newest code enters at the low end
      if (sf_done) begin
        acks_r <= {acks_r[17:0], ack_code};
      end
    end
  end

  // ---------------- de-noising filter and accumulators ----------------
  // newest sample goes to tap 0; filter sees the window after the shift
  logic signed [15:0] wre [9];
  logic signed [15:0] wim [9];
  always_comb begin
    wre[0] = ce_re;
    wim[0] = ce_im;
    for (int i = 1; i < 9; i++) begin
      wre[i] = tre_r[i-1];
      wim[i] = tim_r[i-1];
    end
  end

  // symmetric taps, zero taps skipped
  // pair sums widened first so a full-scale pair cannot wrap
  wire signed [34:0] fre = 35'(wre[4]) * 35'(`ULFB_TAP_CENTRE) +
                           (35'(wre[3]) + 35'(wre[5])) * 35'(`ULFB_TAP_NEAR) +
                           (35'(wre[1]) + 35'(wre[7])) * 35'(`ULFB_TAP_OUTER);
  wire signed [34:0] fim = 35'(wim[4]) * 35'(`ULFB_TAP_CENTRE) +
                           (35'(wim[3]) + 35'(wim[5])) * 35'(`ULFB_TAP_NEAR) +
                           (35'(wim[1]) + 35'(wim[7])) * 35'(`ULFB_TAP_OUTER);
  wire signed [17:0] yre = 18'(fre >>> 15);
  wire signed [17:0] yim = 18'(fim >>> 15);
  // residual of the centre sample against its filtered value
  wire signed [18:0] dre = 19'(wre[4]) - 19'(yre);
  wire signed [18:0] dim = 19'(wim[4]) - 19'(yim);
  wire [47:0] g_inc = 48'(36'(yre) * 36'(yre)) + 48'(36'(yim) * 36'(yim));
  wire [47:0] n_inc = 48'(38'(dre) * 38'(dre)) + 48'(38'(dim) * 38'(dim));
  // sums stand in for means: the shared sample count cancels in the ratio
  wire [47:0] sg_nxt = sg_r + g_inc;
  wire [47:0] sn_nxt = sn_r + n_inc;
  wire [47:0] wg_nxt = wg_r + g_inc;
  wire [47:0] wn_nxt = wn_r + n_inc;

  // estimate, then calibration by range slice
  wire ulfb_quality_t sub_mapped = unbiased(sg_nxt, sn_nxt, refdb_r);
  wire ulfb_quality_t wb_mapped  = unbiased(wg_nxt, wn_nxt, refdb_r);
  wire ulfb_quality_t sub_final  = sat8(16'(sub_mapped) + 16'(lut_r[sub_mapped[7:4]]));
  wire ulfb_quality_t wb_final   = sat8(16'(wb_mapped) + 16'(lut_r[wb_mapped[7:4]]));

  // no allocation mask: partial subbands simply read low
  wire samp     = ce_valid;
  wire sub_done = samp & ce_sub_end;
  wire wb_done  = samp & ce_band_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 9; i++) begin
        tre_r[i] <= 16'sh0000;
        tim_r[i] <= 16'sh0000;
      end
      sg_r      <= 48'h0;
      sn_r      <= 48'h0;
      wg_r      <= 48'h0;
      wn_r      <= 48'h0;
      sub_idx_r <= 4'h0;
      wbq_r     <= 8'sh80;
      for (int i = 0; i < NUM_SUB; i++) begin
        subq_r[i] <= 8'sh80;
      end
    end else if (samp) begin
      for (int i = 0; i < 9; i++) begin
        tre_r[i] <= wre[i];
        tim_r[i] <= wim[i];
      end
      // eight blocks per subband, index counts up from 0
      sg_r <= sub_done ? 48'h0 : sg_nxt;
      sn_r <= sub_done ? 48'h0 : sn_nxt;
      if (sub_done) begin
        if (int'(sub_idx_r) < NUM_SUB) begin
          subq_r[sub_idx_r] <= sub_final;
        end
        sub_idx_r <= wb_done ? 4'h0 : sub_idx_r + 4'h1;
      end
      // wideband spans every subband of the band
      wg_r <= wb_done ? 48'h0 : wg_nxt;
      wn_r <= wb_done ? 48'h0 : wn_nxt;
      if (wb_done) begin
        wbq_r <= wb_final;
        sub_idx_r <= 4'h0;
      end
    end
  end

  // ---------------- payload assembly ----------------
  // byte-wide fields packed most significant first
  logic [`ULFB_PAYLOAD_BITS-1:0] payload;
  always_comb begin
    payload = '0;
    payload[191:182] = frame_r;
    payload[179:160] = acks_r;
    for (int i = 0; i < NUM_SUB; i++) begin
      payload[159 - 8*i -: 8] = subq_r[i];
    end
    payload[159 - 8*NUM_SUB -: 8] = wbq_r;
  end

  // header counts payload bytes only, never padding
  function automatic logic [31:0] word_at(input logic [7:0] idx,
                                          input logic [`ULFB_PAYLOAD_BITS-1:0] p);
    if (idx == 8'h00) begin
      return `ULFB_PAYLOAD_BYTES;
    end else if (idx <= 8'(`ULFB_PAYLOAD_WORDS)) begin
      return p[`ULFB_PAYLOAD_BITS - 32*(int'(idx) - 1) - 1 -: 32];
    end
    return 32'h0000_0000;
  endfunction

  wire        accept  = tx_valid_r & tx_ready;
  wire        last_w  = (widx_r == tbwords_r - 8'h01);
  wire [7:0]  nxt_idx = widx_r + 8'h01;
  wire        start   = frame_tick & ctrl_r[`ULFB_CTRL_ENABLE];

  // one packet per frame; a tick while busy is counted as dropped only while the enable bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ULFB_IDLE;
      widx_r     <= 8'h00;
      snap_r     <= '0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 32'h0000_0000;
      tx_last_r  <= 1'b0;
      sent_r     <= 16'h0000;
      drop_r     <= 16'h0000;
    end else begin
      unique case (state_r)
        ULFB_IDLE: begin
          if (start) begin
            snap_r     <= payload;
            widx_r     <= 8'h00;
            tx_valid_r <= 1'b1;
            tx_data_r  <= `ULFB_PAYLOAD_BYTES;
            tx_last_r  <= 1'b0;
            state_r    <= ULFB_SEND;
          end
        end
        ULFB_SEND: begin
          if (start) begin
            drop_r <= drop_r + 16'h0001;
          end
          if (accept) begin
            if (tx_last_r) begin
              tx_valid_r <= 1'b0;
              tx_last_r  <= 1'b0;
              tx_data_r  <= 32'h0000_0000;
              sent_r     <= sent_r + 16'h0001;
              state_r    <= ULFB_IDLE;
            end else begin
              widx_r    <= nxt_idx;
              tx_data_r <= word_at(nxt_idx, snap_r);
              tx_last_r <= (nxt_idx == tbwords_r - 8'h01);
            end
          end else if (!tx_last_r && last_w) begin
            tx_last_r <= 1'b1;
          end
        end
        default: state_r <= ULFB_IDLE;
      endcase
    end
  end

  // ---------------- request confirmation ----------------
  // every request confirmed; uplink setup refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnf_valid_r  <= 1'b0;
      cnf_status_r <= `ULFB_CNF_OK;
    end else begin
      cnf_valid_r <= req_valid;
      if (req_valid) begin
        cnf_status_r <= (req_type == `ULFB_REQ_UL_SETUP) ? `ULFB_CNF_UNSUPP : `ULFB_CNF_OK;
      end
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign tx_valid   = tx_valid_r;
  assign tx_data    = tx_data_r;
  assign tx_last    = tx_last_r;
  assign cnf_valid  = cnf_valid_r;
  assign cnf_status = cnf_status_r;

endmodule

// >>> ulfb_framer_chk.sv
// port assertions of the feedback framer
`timescale 1ns/1ns
`include "ulfb_map.svh"
module ulfb_framer_chk #(
  parameter int NUM_SUB = 13
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        frame_tick,
  input wire logic        req_valid,
  input wire logic [7:0]  req_type,
  input wire logic        cnf_valid,
  input wire logic [7:0]  cnf_status,
  input wire logic        tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic        tx_last,
  input wire logic        tx_ready
);
  // quality bytes end here; all later words are spare or padding
  localparam int FIRST_ZERO = 2 + (NUM_SUB + 4) / 4;
  logic       acc;
  logic [7:0] wcnt_r;
  logic [7:0] wcnt_nxt;
  assign acc = tx_valid && tx_ready;
  assign wcnt_nxt = !acc ? wcnt_r : (tx_last ? 8'h00 : wcnt_r + 8'h01);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) wcnt_r <= 8'h00;
    else wcnt_r <= wcnt_nxt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CNF_ANY:
    assert property (req_valid |=> cnf_valid) else $error("request without confirmation");
  AST_CNF_CAUSE:
    assert property (cnf_valid |-> $past(req_valid)) else $error("confirmation without request");
  AST_UL_SETUP_REFUSED:
    assert property (req_valid && req_type == `ULFB_REQ_UL_SETUP |=>
      cnf_status == `ULFB_CNF_UNSUPP) else $error("uplink setup not refused");
  AST_HDR_FIRST:
    assert property (tx_valid && wcnt_r == 8'h00 |-> tx_data == `ULFB_PAYLOAD_BYTES)
      else $error("header is not payload byte count");
  AST_PAD_ZERO:
    assert property (tx_valid && wcnt_r >= FIRST_ZERO |-> tx_data == 32'h0000_0000)
      else $error("spare or padding word not zero");
  AST_WORD_COUNT:
    assert property (tx_valid && tx_last |-> wcnt_r >= 8'h06) else $error("packet too short");
  AST_HOLD:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("stalled word changed");
  AST_SPARE_BITS:
    assert property (tx_valid && wcnt_r == 8'h01 |-> tx_data[21:20] == 2'h0)
      else $error("spare bits of word one set");
  AST_START:
    assert property ($rose(tx_valid) |-> $past(frame_tick)) else $error("packet not started by tick");

  cover property (acc && tx_last);
  cover property (tx_valid && !tx_ready);
  cover property (req_valid && req_type == `ULFB_REQ_UL_SETUP);
endmodule

bind ulfb_framer ulfb_framer_chk #(.NUM_SUB(NUM_SUB)) u_chk (.pclk, .presetn, .frame_tick,
  .req_valid, .req_type, .cnf_valid, .cnf_status, .tx_valid, .tx_data, .tx_last, .tx_ready);

// >>> ulfb_sink.sv
// far-side model: uplink stack draining the packet stream
`timescale 1ns/1ns
module ulfb_sink (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_last,
  output logic             tx_ready
);
  logic [31:0] words[$];
  int          pkts;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      pkts = 0;
    end else begin
      if (tx_valid && tx_ready) begin
        words.push_back(tx_data);
        if (tx_last) pkts++;
      end
      tx_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule

// >>> ulfb_framer_tb.sv
// self-checking bench of the feedback framer
`timescale 1ns/1ns
`include "ulfb_map.svh"
module ulfb_framer_tb;
  import ulfb_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, req_type, cnf_status;
  logic [31:0] pwdata, prdata, tx_data, rd, w1, v;
  logic        frame_tick, sf_done, sf_crc_ok, sf_ctrl_ok, stall, err;
  logic        ce_valid, ce_sub_end, ce_band_end, tx_valid, tx_last, tx_ready;
  logic        req_valid, cnf_valid;
  logic signed [15:0] ce_re, ce_im;
  logic [19:0] ack_m;
  logic [7:0]  a;
  int          error_cnt, checks_done, fc_m;
  logic [7:0]  rst_a[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rst_v[7] = '{32'h1, 32'h10, 32'h0, 32'h0, 32'h80, 32'h0, 32'hF_FFFF};

  ulfb_framer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_tick, .sf_done, .sf_crc_ok, .sf_ctrl_ok, .ce_valid, .ce_re,
    .ce_im, .ce_sub_end, .ce_band_end, .tx_valid, .tx_data, .tx_last, .tx_ready,
    .req_valid, .req_type, .cnf_valid, .cnf_status);
  ulfb_sink u_sink (.pclk, .presetn, .stall, .tx_valid, .tx_data, .tx_last, .tx_ready);

  always #20 pclk = ~pclk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // no wait-state count assumed; bounded poll of pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    logic to;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    to = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (to) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp, input logic e);
    apb(1'b0, ad, 32'h0);
    chk("read data", exp, rd);
    chk("slave error", {31'h0, e}, {31'h0, err});
  endtask

  task automatic tick();
    frame_tick <= 1'b1;
    @(posedge pclk);
    frame_tick <= 1'b0;
    fc_m = (fc_m + 1) % 1024;
    @(posedge pclk);
  endtask

  task automatic subframe(input logic crc, input logic ctl);
    sf_done <= 1'b1;
    sf_crc_ok <= crc;
    sf_ctrl_ok <= ctl;
    @(posedge pclk);
    sf_done <= 1'b0;
    ack_m = {ack_m[17:0], ctl ? {1'b0, crc} : `ULFB_ACK_DTX};
    @(posedge pclk);
  endtask

  task automatic pkt(input int nw, input logic [31:0] wa);
    logic [31:0] e;
    int n;
    n = 0;
    while (u_sink.words.size() < nw && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) begin
      error_cnt++;
      close_out();
    end
    repeat (3) @(posedge pclk);
    chk("word count", nw, u_sink.words.size());
    for (int i = 0; i < nw && i < u_sink.words.size(); i++) begin
      e = (i == 0) ? `ULFB_PAYLOAD_BYTES : (i == 1) ? wa : (i < 5) ? 32'h8080_8080 :
          (i == 5) ? 32'h8080_0000 : 32'h0;
      chk("packet word", e, u_sink.words[i]);
    end
    u_sink.words.delete();
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, frame_tick, sf_done, sf_crc_ok, sf_ctrl_ok} = '0;
    {ce_valid, ce_sub_end, ce_band_end, req_valid, stall} = '0;
    paddr = '0;
    pwdata = '0;
    ce_re = '0;
    ce_im = '0;
    req_type = '0;
    error_cnt = 0;
    checks_done = 0;
    fc_m = 0;
    ack_m = 20'hF_FFFF;
    void'($urandom(25));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rst_a[i]) rdchk(rst_a[i], rst_v[i], 1'b0);
    rdchk(8'h30, 32'h0, 1'b1);
    rdchk(8'h02, 32'h0, 1'b1);
    apb(1'b1, 8'h0C, 32'h5);
    chk("read-only write", 32'h1, {31'h0, err});
    rdchk(8'h0C, 32'h0, 1'b0);
    for (int i = 0; i < 17; i++) begin
      a = (i == 16) ? 8'h08 : 8'h40 + 8'(4 * i);
      v = 32'($urandom_range(255));
      apb(1'b1, a, v);
      rdchk(a, v, 1'b0);
    end
    apb(1'b1, 8'h00, 32'h3);
    rdchk(8'h00, 32'h3, 1'b0);
    apb(1'b1, 8'h04, 32'h9);
    repeat (12) subframe(1'($urandom_range(1)), 1'($urandom_range(1)));
    rdchk(8'h18, {12'h0, ack_m}, 1'b0);
    for (int t = 1; t < 4; t++) begin
      req_valid <= 1'b1;
      req_type <= 8'(t);
      @(posedge pclk);
      req_valid <= 1'b0;
      #1;
      chk("confirm valid", 32'h1, {31'h0, cnf_valid});
      chk("confirm status", (t == 1) ? 32'h1 : 32'h0, {24'h0, cnf_status});
      @(posedge pclk);
    end
    stall <= 1'b1;
    w1 = {fc_m[9:0], 2'h0, ack_m};
    tick();
    repeat (3) @(posedge pclk);
    tick();
    pkt(9, w1);
    stall <= 1'b0;
    rdchk(8'h14, 32'h0001_0001, 1'b0);
    rdchk(8'h0C, 32'h2, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    while (fc_m != 1023) tick();
    rdchk(8'h0C, 32'h3FF, 1'b0);
    tick();
    rdchk(8'h0C, 32'h0, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'h3);
    rdchk(8'h04, 32'h7, 1'b0);
    w1 = {fc_m[9:0], 2'h0, ack_m};
    tick();
    pkt(7, w1);
    rdchk(8'h14, 32'h0001_0002, 1'b0);
    for (int i = 0; i < 104; i++) begin
      ce_valid <= 1'b1;
      ce_re <= 16'($urandom);
      ce_im <= 16'($urandom);
      ce_sub_end <= (i % 8 == 7);
      ce_band_end <= (i == 103);
      @(posedge pclk);
    end
    ce_valid <= 1'b0;
    ce_sub_end <= 1'b0;
    ce_band_end <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    chk("wideband read", 32'h0, {31'h0, err});
    close_out();
  end
endmodule
